// File: verilog/tmc_pkg.sv
package tmc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Memory geometry
  localparam int unsigned WORD_W    = 32;
  localparam int unsigned NUM_WORDS = 32;
  localparam int unsigned ADDR_W    = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Word indices
  localparam logic [4:0] IDX_UID      = 5'h00;
  localparam logic [4:0] IDX_FAB      = 5'h01;
  localparam logic [4:0] IDX_CFG      = 5'h02;
  localparam logic [4:0] IDX_WLOCK    = 5'h03;
  localparam logic [4:0] IDX_RLOCK    = 5'h04;
  localparam logic [4:0] IDX_USER_LO  = 5'h05;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration word fields
  localparam int unsigned CFG_FSCI_LSB  = 28;
  localparam int unsigned CFG_FWI_LSB   = 24;
  localparam int unsigned CFG_SDR_BIT   = 23;
  localparam int unsigned CFG_T2R8_BIT  = 22;
  localparam int unsigned CFG_T2R4_BIT  = 21;
  localparam int unsigned CFG_T2R2_BIT  = 20;
  localparam int unsigned CFG_R2T8_BIT  = 19;
  localparam int unsigned CFG_R2T4_BIT  = 18;
  localparam int unsigned CFG_R2T2_BIT  = 17;
  localparam int unsigned CFG_NL4_BIT   = 16;
  localparam int unsigned CFG_P2P_BIT   = 15;
  localparam int unsigned CFG_IRQEN_BIT = 13;
  localparam int unsigned CFG_MODE_LSB  = 11;
  localparam logic [31:0] CFG_RESET     = 32'h2600_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Operating modes
  typedef enum logic [1:0] {
    TMC_MODE_L4    = 2'h0,
    TMC_MODE_L3    = 2'h1,
    TMC_MODE_FRAME = 2'h2,
    TMC_MODE_TRANS = 2'h3
  } tmc_mode_e;

  ////////////////////////////////////////////////////////////////////////////
  // Block first-byte classes, SAK bits, write answers
  localparam logic [7:0] FB_PROP_MASK = 8'hC0;
  localparam logic [7:0] FB_PROP_VAL  = 8'h40;
  localparam logic [7:0] FB_RATS      = 8'hE0;
  localparam logic [7:0] FB_DESEL_MSK = 8'hF7;
  localparam logic [7:0] FB_DESEL_VAL = 8'hC2;
  localparam logic [7:0] FB_PPS_MASK  = 8'hF0;
  localparam logic [7:0] FB_PPS_VAL   = 8'hD0;
  localparam logic [7:0] SAK_L4_BIT   = 8'h20;
  localparam logic [7:0] SAK_P2P_BIT  = 8'h40;
  localparam logic [1:0] WR_OK        = 2'h0;
  localparam logic [1:0] WR_LOCKED    = 2'h1;
  localparam logic [1:0] WR_RF_BUSY   = 2'h2;

endpackage : tmc_pkg

// File: verilog/tmc_core.sv
// Contract
// RULE_01: Reader puts its assigned card identifier in each block's second byte.
// RULE_02: Self-executed block with wrong identifier is dropped silently.
// RULE_03: FIFO-routed blocks skip identifier filtering; host checks identifier.
// RULE_04: Level-3 mode: same activation, every later block goes to FIFO.
// RULE_05: With irq enable set, interrupt on entering active state; code raises it in level-4 and level-3 modes only.
// RULE_06: Level-3 and transparent modes let SPI reach memory during field.
// RULE_07: Transparent, select high: MOSI drives load modulator directly.
// RULE_08: Transparent, select high: carrier clock to MISO, demod to IRQ.
// RULE_09: Transparent, select low: pins return to serial-interface functions.
// RULE_10: Memory of 32 words by 32 bits, reachable from RF and SPI.
// RULE_11: Words: identifier, fabrication, config, write lock, read lock, user.
// RULE_12: Writes to read-only words are rejected.
// RULE_13: Read-write word refuses writes once its write-lock bit is set.
// RULE_14: One-time-programmable bits never return from one to zero.
// RULE_15: Identifier word holds low four bytes of seven-byte identifier.
// RULE_16: Config bits 31..28 frame-size code, default 2h.
// RULE_17: Config bits 27..24 frame-waiting code, default 6h.
// RULE_18: Symmetric-rate bit reported in answer-to-select rate byte.
// RULE_19: Bits 22..20 advertise tag-to-reader rates 848, 424, 212k.
// RULE_20: Bits 19..17 advertise reader-to-tag rates 848, 424, 212k.
// RULE_21: Not-level-4 bit clears protocol support in cascade-2 select ack.
// RULE_22: Passive-target bit flagged in cascade-2 select ack; code sends 00h instead while not-level-4 is set.
// RULE_23: Mode field: 00 L4, 01 L3, 10 framing, 11 transparent.
`timescale 1ns/100ps

module tmc_core #(
  parameter logic [31:0] UID_LOW_INIT = 32'h0000_0000, // Arbitrary value
  parameter logic [31:0] FAB_INIT     = 32'h0000_0000  // Arbitrary value
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  // Received block from the RF framer
  input  wire logic        blk_valid_i,
  input  wire logic [7:0]  blk_first_i,
  input  wire logic [7:0]  blk_cid_i,
  input  wire logic [3:0]  own_cid_i,
  input  wire logic        sak_cl2_sent_i,
  input  wire logic        field_on_i,
  output logic             blk_to_fifo_o,
  output logic             blk_execute_o,
  output logic             blk_drop_o,
  output logic [7:0]       sak_cl2_o,
  output logic [7:0]       ats_t0_o,
  output logic [7:0]       ats_ta_o,
  output logic [7:0]       ats_tb_o,
  output logic [1:0]       mode_o,
  // Memory access port, shared by RF and SPI sides
  input  wire logic        mem_wr_i,
  input  wire logic        mem_rd_i,
  input  wire logic        mem_from_spi_i,
  input  wire logic [4:0]  mem_addr_i,
  input  wire logic [31:0] mem_wdata_i,
  output logic             mem_ack_o,
  output logic [1:0]       mem_status_o,
  output logic [31:0]      mem_rdata_o,
  // Analog front end
  input  wire logic        afe_clk_i,
  input  wire logic        afe_demod_i,
  output logic             afe_mod_o,
  // Serial pins
  input  wire logic        ss_n_pin_i,
  input  wire logic        mosi_pin_i,
  input  wire logic        spi_miso_i,
  input  wire logic        spi_irq_i,
  output logic             miso_o,
  output logic             miso_oe_o,
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers for pins
  logic [1:0] ss_sync_ff;
  logic [1:0] mosi_sync_ff;
  logic [1:0] aclk_sync_ff;
  logic [1:0] demod_sync_ff;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ss_sync_ff    <= 2'h3;
      mosi_sync_ff  <= 2'h0;
      aclk_sync_ff  <= 2'h0;
      demod_sync_ff <= 2'h0;
    end else begin
      ss_sync_ff    <= {ss_sync_ff[0], ss_n_pin_i};
      mosi_sync_ff  <= {mosi_sync_ff[0], mosi_pin_i};
      aclk_sync_ff  <= {aclk_sync_ff[0], afe_clk_i};
      demod_sync_ff <= {demod_sync_ff[0], afe_demod_i};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Nonvolatile memory
  logic [31:0] mem_ff [tmc_pkg::NUM_WORDS]; // see RULE_10
  logic        init_done_ff;

  logic [31:0] cfg_w;
  logic [31:0] wlock_w;
  logic [31:0] rlock_w;
  assign cfg_w   = mem_ff[tmc_pkg::IDX_CFG];
  assign wlock_w = mem_ff[tmc_pkg::IDX_WLOCK];
  assign rlock_w = mem_ff[tmc_pkg::IDX_RLOCK];

  tmc_pkg::tmc_mode_e mode_w;
  assign mode_w = tmc_pkg::tmc_mode_e'(cfg_w[tmc_pkg::CFG_MODE_LSB +: 2]); // see RULE_23

  logic trans_w;
  logic ss_high_w;
  assign trans_w   = (mode_w == tmc_pkg::TMC_MODE_TRANS);
  assign ss_high_w = ss_sync_ff[1];

  logic ro_word_w;
  logic otp_word_w;
  logic spi_blocked_w;
  logic [1:0] nxt_status;
  // Word 0 and 1 are read-only; lock words are OTP
  assign ro_word_w  = (mem_addr_i == tmc_pkg::IDX_UID) ||
                      (mem_addr_i == tmc_pkg::IDX_FAB); // see RULE_11
  assign otp_word_w = (mem_addr_i == tmc_pkg::IDX_WLOCK) ||
                      (mem_addr_i == tmc_pkg::IDX_RLOCK);
  // Level-4 and framing modes keep the field owner exclusive
  assign spi_blocked_w = mem_from_spi_i && field_on_i &&
                         (mode_w != tmc_pkg::TMC_MODE_L3) && !trans_w; // see RULE_06

  always_comb begin
    if (spi_blocked_w) begin
      nxt_status = tmc_pkg::WR_RF_BUSY;
    end else if (ro_word_w || wlock_w[mem_addr_i]) begin
      nxt_status = tmc_pkg::WR_LOCKED; // see RULE_12 see RULE_13
    end else begin
      nxt_status = tmc_pkg::WR_OK;
    end
  end

  // Memory contents are loaded once after reset; the array has no reset path
  always_ff @(posedge core_clk_i) begin
    if (!init_done_ff) begin
      for (int i = 0; i < tmc_pkg::NUM_WORDS; i++) begin
        mem_ff[i] <= 32'h0000_0000;
      end
      mem_ff[tmc_pkg::IDX_UID] <= UID_LOW_INIT; // see RULE_15
      mem_ff[tmc_pkg::IDX_FAB] <= FAB_INIT;
      mem_ff[tmc_pkg::IDX_CFG] <= tmc_pkg::CFG_RESET; // see RULE_16 see RULE_17
    end else if (mem_wr_i && nxt_status == tmc_pkg::WR_OK) begin
      if (otp_word_w) begin
        mem_ff[mem_addr_i] <= mem_ff[mem_addr_i] | mem_wdata_i; // see RULE_14
      end else begin
        mem_ff[mem_addr_i] <= mem_wdata_i;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      init_done_ff <= 1'b0;
    end else begin
      init_done_ff <= 1'b1;
    end
  end

  // Read answer; RF reads of locked user words give zero
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_ack_o    <= 1'b0;
      mem_status_o <= tmc_pkg::WR_OK;
      mem_rdata_o  <= 32'h0000_0000;
    end else begin
      mem_ack_o <= (mem_wr_i || mem_rd_i) && init_done_ff;
      if (mem_wr_i) begin
        mem_status_o <= nxt_status;
      end else if (mem_rd_i) begin
        mem_status_o <= spi_blocked_w ? tmc_pkg::WR_RF_BUSY : tmc_pkg::WR_OK;
        if (spi_blocked_w || (!mem_from_spi_i && mem_addr_i >= tmc_pkg::IDX_USER_LO &&
            rlock_w[mem_addr_i])) begin
          mem_rdata_o <= 32'h0000_0000;
        end else begin
          mem_rdata_o <= mem_ff[mem_addr_i];
        end
      end
    end
  end

  a_cfg_default: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_16
    $rose(init_done_ff) |-> cfg_w == tmc_pkg::CFG_RESET &&
    mem_ff[tmc_pkg::IDX_UID] == UID_LOW_INIT)
    else $error("memory defaults not loaded");

  a_mem_ack: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_10
    init_done_ff && (mem_wr_i || mem_rd_i) |=> mem_ack_o)
    else $error("memory request not acknowledged");

  a_locked_read: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_11
    init_done_ff && mem_rd_i && !mem_wr_i && !mem_from_spi_i && rlock_w[mem_addr_i] &&
    mem_addr_i >= tmc_pkg::IDX_USER_LO |=> mem_rdata_o == 32'h0000_0000)
    else $error("read-locked word shown to the field side");

  a_spi_block: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_06
    init_done_ff && mem_wr_i && spi_blocked_w |=> mem_status_o == tmc_pkg::WR_RF_BUSY)
    else $error("spi write not refused in a field-owned mode");

  a_ro_status: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_12
    init_done_ff && mem_wr_i && ro_word_w && !spi_blocked_w |=>
    mem_status_o == tmc_pkg::WR_LOCKED)
    else $error("read-only word write not refused");

  a_rlock_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_14
    init_done_ff ##1 init_done_ff |-> (($past(rlock_w) & ~rlock_w) == 32'h0000_0000))
    else $error("read-lock bit cleared");

  ////////////////////////////////////////////////////////////////////////////
  // Block routing
  logic self_exec_w;
  logic cid_ok_w;
  assign self_exec_w = (mode_w == tmc_pkg::TMC_MODE_L4) && (
                       ((blk_first_i & tmc_pkg::FB_PROP_MASK) == tmc_pkg::FB_PROP_VAL) ||
                       (blk_first_i == tmc_pkg::FB_RATS) ||
                       ((blk_first_i & tmc_pkg::FB_PPS_MASK) == tmc_pkg::FB_PPS_VAL) ||
                       ((blk_first_i & tmc_pkg::FB_DESEL_MSK) == tmc_pkg::FB_DESEL_VAL));
  // The reader assigns the identifier in the low nibble of the second byte
  assign cid_ok_w = (blk_cid_i[3:0] == own_cid_i); // see RULE_01

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blk_to_fifo_o <= 1'b0;
      blk_execute_o <= 1'b0;
      blk_drop_o    <= 1'b0;
    end else begin
      // Level-3 never executes; FIFO blocks are unfiltered
      blk_to_fifo_o <= blk_valid_i && !self_exec_w; // see RULE_03 see RULE_04
      blk_execute_o <= blk_valid_i && self_exec_w && cid_ok_w; // see RULE_02
      blk_drop_o    <= blk_valid_i && self_exec_w && !cid_ok_w; // see RULE_02
    end
  end

  a_exec_match: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_02
    blk_valid_i && self_exec_w && cid_ok_w |=> blk_execute_o && !blk_drop_o && !blk_to_fifo_o)
    else $error("matching self-executed block not run");

  a_l4_only_exec: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_04
    blk_valid_i && mode_w != tmc_pkg::TMC_MODE_L4 |=> !blk_execute_o && !blk_drop_o)
    else $error("block executed outside level-4 mode");

  ////////////////////////////////////////////////////////////////////////////
  // Select acknowledge and answer-to-select bytes
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sak_cl2_o <= 8'h00;
      ats_t0_o  <= 8'h00;
      ats_ta_o  <= 8'h00;
      ats_tb_o  <= 8'h00;
      mode_o    <= 2'h0;
    end else begin
      // Not-level-4 wins over passive-target when both are set
      sak_cl2_o <= cfg_w[tmc_pkg::CFG_NL4_BIT] ? 8'h00 :
                   (cfg_w[tmc_pkg::CFG_P2P_BIT] ? (tmc_pkg::SAK_L4_BIT | tmc_pkg::SAK_P2P_BIT)
                                                : tmc_pkg::SAK_L4_BIT); // see RULE_21 see RULE_22
      ats_t0_o  <= {4'h7, cfg_w[tmc_pkg::CFG_FSCI_LSB +: 4]}; // see RULE_16
      ats_ta_o  <= {cfg_w[tmc_pkg::CFG_SDR_BIT],
                    cfg_w[tmc_pkg::CFG_T2R8_BIT],
                    cfg_w[tmc_pkg::CFG_T2R4_BIT],
                    cfg_w[tmc_pkg::CFG_T2R2_BIT], 1'b0,
                    cfg_w[tmc_pkg::CFG_R2T8_BIT],
                    cfg_w[tmc_pkg::CFG_R2T4_BIT],
                    cfg_w[tmc_pkg::CFG_R2T2_BIT]}; // see RULE_18 see RULE_19 see RULE_20
      ats_tb_o  <= {cfg_w[tmc_pkg::CFG_FWI_LSB +: 4], 4'h0}; // see RULE_17
      mode_o    <= cfg_w[tmc_pkg::CFG_MODE_LSB +: 2];
    end
  end

  a_sak_nl4: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_21
    cfg_w[tmc_pkg::CFG_NL4_BIT] |=> sak_cl2_o == 8'h00)
    else $error("select ack still claims level-4");

  a_sak_p2p: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_22
    !cfg_w[tmc_pkg::CFG_NL4_BIT] && cfg_w[tmc_pkg::CFG_P2P_BIT] |=>
    (sak_cl2_o & tmc_pkg::SAK_P2P_BIT) != 8'h00)
    else $error("passive target not flagged");

  a_fsc_report: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_16
    1'b1 |=> ats_t0_o[3:0] == $past(cfg_w[tmc_pkg::CFG_FSCI_LSB +: 4]))
    else $error("frame-size code not reported");

  a_rate_report: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_18
    1'b1 |=> ats_ta_o[7] == $past(cfg_w[tmc_pkg::CFG_SDR_BIT]))
    else $error("symmetric-rate bit not reported");

  ////////////////////////////////////////////////////////////////////////////
  // Active-entry interrupt and pin multiplexing
  logic active_irq_ff;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active_irq_ff <= 1'b0;
    end else if (sak_cl2_sent_i && cfg_w[tmc_pkg::CFG_IRQEN_BIT] &&
                 (mode_w == tmc_pkg::TMC_MODE_L4 || mode_w == tmc_pkg::TMC_MODE_L3)) begin
      active_irq_ff <= 1'b1; // see RULE_05
    end else if (!ss_high_w) begin
      active_irq_ff <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      afe_mod_o <= 1'b0;
      miso_o    <= 1'b0;
      miso_oe_o <= 1'b0;
      irq_o     <= 1'b0;
    end else if (trans_w && ss_high_w) begin
      afe_mod_o <= mosi_sync_ff[1]; // see RULE_07
      miso_o    <= aclk_sync_ff[1]; // see RULE_08
      miso_oe_o <= 1'b1;
      irq_o     <= demod_sync_ff[1]; // see RULE_08
    end else begin
      afe_mod_o <= 1'b0;
      miso_o    <= spi_miso_i; // see RULE_09
      miso_oe_o <= !ss_high_w;
      irq_o     <= spi_irq_i | active_irq_ff;
    end
  end

  a_trans_clk: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_08
    trans_w && ss_high_w |=> miso_o == $past(aclk_sync_ff[1]) && miso_oe_o)
    else $error("carrier clock not on miso");

  a_trans_demod: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_08
    trans_w && ss_high_w |=> irq_o == $past(demod_sync_ff[1]))
    else $error("demodulator not on irq");

  a_ss_low_oe: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_09
    !ss_high_w |=> miso_oe_o)
    else $error("miso not driven while selected");

  a_mod_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_07
    !trans_w |=> !afe_mod_o)
    else $error("modulator driven outside transparent mode");

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_drop_on_mismatch: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_02
    blk_valid_i && self_exec_w && !cid_ok_w |=> blk_drop_o && !blk_execute_o && !blk_to_fifo_o)
    else $error("mismatched identifier not dropped");

  a_fifo_unfiltered: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_03
    blk_valid_i && !self_exec_w |=> blk_to_fifo_o)
    else $error("fifo block was filtered");

  a_l3_no_exec: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_04
    blk_valid_i && mode_w == tmc_pkg::TMC_MODE_L3 |=> blk_to_fifo_o && !blk_execute_o)
    else $error("level-3 block executed");

  // The flag is set one edge after the pulse and reaches the pin one edge later
  a_irq_entry: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_05
    sak_cl2_sent_i && cfg_w[tmc_pkg::CFG_IRQEN_BIT] && ss_high_w &&
    (mode_w == tmc_pkg::TMC_MODE_L3 || mode_w == tmc_pkg::TMC_MODE_L4) |=> ##1 irq_o)
    else $error("no active-entry interrupt");

  a_ro_protect: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_12
    init_done_ff && mem_wr_i && ro_word_w |=>
    mem_ff[$past(mem_addr_i)] == $past(mem_ff[mem_addr_i]))
    else $error("read-only word changed");

  // A field-owned refusal reports busy first, so it is left out here
  a_wlock_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_13
    init_done_ff && mem_wr_i && wlock_w[mem_addr_i] && !spi_blocked_w |=>
    mem_status_o == tmc_pkg::WR_LOCKED)
    else $error("locked word write accepted");

  a_otp_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_14
    init_done_ff ##1 init_done_ff |-> (($past(wlock_w) & ~wlock_w) == 32'h0000_0000))
    else $error("otp bit cleared");

  a_trans_mod: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_07
    trans_w && ss_high_w |=> afe_mod_o == $past(mosi_sync_ff[1]))
    else $error("modulator not following mosi");

  a_trans_release: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_09
    trans_w && !ss_high_w |=> miso_o == $past(spi_miso_i) && !afe_mod_o)
    else $error("pins not returned to serial use");

  a_spi_busy: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see RULE_06
    init_done_ff && mem_wr_i && mem_from_spi_i && field_on_i && trans_w |=>
    mem_status_o != tmc_pkg::WR_RF_BUSY)
    else $error("spi blocked in transparent mode");

endmodule : tmc_core

// File: tb/tmc_rf_model.sv
`timescale 1ns/100ps

module tmc_rf_model (
  // Clock and frame window
  input  wire logic core_clk_i,
  input  wire logic frame_i,
  // Front-end lines seen by the tag
  output logic      afe_clk_o,
  output logic      afe_demod_o
);
  logic [3:0] cnt = 4'h0;

  initial begin
    afe_clk_o   = 1'b0;
    afe_demod_o = 1'b1;
  end

  // Carrier stands still between frames, so a design that ignores it shows up
  always @(negedge core_clk_i) begin
    if (frame_i) begin
      cnt         <= cnt + 4'h1;
      afe_clk_o   <= cnt[1];
      afe_demod_o <= 1'($urandom % 2);
    end
  end
endmodule : tmc_rf_model

// File: tb/tb_tmc_core.sv
`timescale 1ns/100ps

module tb_tmc_core;
  localparam logic [31:0] UID_INIT = 32'h1234_5678; // Arbitrary value
  localparam logic [31:0] FAB_INIT = 32'h9abc_def0; // Arbitrary value
  logic        core_clk_i = 1'b0, rst_n_i = 1'b0, blk_valid_i = 1'b0;
  logic [7:0]  blk_first_i = 8'h00, blk_cid_i = 8'h00;
  logic [3:0]  own_cid_i = 4'h0;
  logic        sak_cl2_sent_i = 1'b0, field_on_i = 1'b0, frame = 1'b0;
  logic        mem_wr_i = 1'b0, mem_rd_i = 1'b0, mem_from_spi_i = 1'b0;
  logic [4:0]  mem_addr_i = 5'h00;
  logic [31:0] mem_wdata_i = 32'h0000_0000;
  logic        ss_n_pin_i = 1'b1, mosi_pin_i = 1'b0, spi_miso_i = 1'b0, spi_irq_i = 1'b0;
  logic        afe_clk_i, afe_demod_i, blk_to_fifo_o, blk_execute_o, blk_drop_o;
  logic        mem_ack_o, afe_mod_o, miso_o, miso_oe_o, irq_o;
  logic [7:0]  sak_cl2_o, ats_t0_o, ats_ta_o, ats_tb_o;
  logic [1:0]  mode_o, mem_status_o;
  logic [31:0] mem_rdata_o;
  int          mismatches = 0;
  int          num_checks = 0;
  int          mem [32];
  int          qa [$];
  int          qb [$];
  int          qc [$];

  tmc_core #(.UID_LOW_INIT(UID_INIT), .FAB_INIT(FAB_INIT)) u_tmc_core (.core_clk_i, .rst_n_i,
    .blk_valid_i, .blk_first_i, .blk_cid_i, .own_cid_i, .sak_cl2_sent_i, .field_on_i,
    .blk_to_fifo_o, .blk_execute_o, .blk_drop_o, .sak_cl2_o, .ats_t0_o, .ats_ta_o,
    .ats_tb_o, .mode_o, .mem_wr_i, .mem_rd_i, .mem_from_spi_i, .mem_addr_i, .mem_wdata_i,
    .mem_ack_o, .mem_status_o, .mem_rdata_o, .afe_clk_i, .afe_demod_i, .afe_mod_o,
    .ss_n_pin_i, .mosi_pin_i, .spi_miso_i, .spi_irq_i, .miso_o, .miso_oe_o, .irq_o);

  tmc_rf_model u_tmc_rf_model (.core_clk_i, .frame_i(frame), .afe_clk_o(afe_clk_i),
    .afe_demod_o(afe_demod_i));

  always #20 core_clk_i = ~core_clk_i;

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : close_out

  // Memory model: status and read data worked out before the request goes out
  task automatic mem_op(input bit wr, input bit spi, input int a, input int d);
    int st, rd, m, n;
    m  = (mem[2] >> 11) & 3;
    st = 0;
    if (spi && field_on_i && m % 2 == 0) st = 2;
    else if (wr && (a < 2 || mem[3][a])) st = 1;
    else if (wr) mem[a] = (a == 3 || a == 4) ? mem[a] | d : d;
    rd = (st == 2 || (!spi && a >= 5 && mem[4][a])) ? 0 : mem[a];
    @(negedge core_clk_i);
    mem_wr_i       = wr;
    mem_rd_i       = !wr;
    mem_from_spi_i = spi;
    mem_addr_i     = a[4:0];
    mem_wdata_i    = d;
    for (n = 0; n < 4 && mem_ack_o !== 1'b1; n++) begin
      @(negedge core_clk_i);
      mem_wr_i = 1'b0;
      mem_rd_i = 1'b0;
    end
    if (mem_ack_o !== 1'b1) begin
      mismatches++;
      close_out();
    end
    check(mem_status_o, st);
    if (!wr) check(mem_rdata_o, rd);
  endtask : mem_op

  task automatic check_cfg();
    logic [31:0] c;
    c = mem[2];
    repeat (2) @(negedge core_clk_i);
    check(ats_t0_o, {4'h7, c[31:28]});
    check(ats_tb_o, {c[27:24], 4'h0});
    check(ats_ta_o, {c[23:20], 1'b0, c[19:17]});
    check(sak_cl2_o, c[16] ? 8'h00 : {1'b0, c[15], 6'h20});
    check(mode_o, c[12:11]);
  endtask : check_cfg

  // Back-to-back blocks; result of one is checked while the next is presented
  task automatic blocks();
    logic [7:0] tbl [10] = '{8'h40, 8'hE0, 8'hD3, 8'hC2, 8'hCA, 8'h00, 8'h80,
                             8'hF0, 8'hE1, 8'hC0};
    int f, c, pe, i;
    bit x;
    pe = 0;
    for (i = 0; i <= 20; i++) begin
      @(negedge core_clk_i);
      if (i > 0) check({blk_drop_o, blk_execute_o, blk_to_fifo_o}, pe);
      f = tbl[i % 10];
      c = ($urandom & 32'h0000_00F0) | (own_cid_i ^ (i / 10));
      blk_valid_i = (i < 20);
      blk_first_i = f[7:0];
      blk_cid_i   = c[7:0];
      x = ((mem[2] >> 11) & 3) == 0 && ((f & 8'hC0) == 8'h40 || f == 8'hE0 ||
          (f & 8'hF0) == 8'hD0 || (f & 8'hF7) == 8'hC2);
      pe = !x ? 1 : (c % 16 == own_cid_i) ? 2 : 4;
    end
  endtask : blocks

  task automatic done(input string s);
    $display("%s finished", s);
  endtask : done

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int a, b, i, m;
    void'($urandom(32'hcaf1));
    own_cid_i = 4'($urandom % 16);
    mem       = '{default: 0};
    mem[0]    = UID_INIT;
    mem[1]    = FAB_INIT;
    mem[2]    = 32'h2600_0000;
    repeat (20) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    repeat (2) @(negedge core_clk_i);
    for (a = 0; a < 5; a++) mem_op(0, 0, a, 0);
    check_cfg();
    for (a = 0; a < 2; a++) mem_op(1, a, a, $urandom);
    for (a = 0; a < 2; a++) mem_op(0, 1, a, 0);
    for (i = 0; i < 8; i++) begin
      a = (i < 2) ? 5 + 26 * i : 5 + $urandom % 27;
      mem_op(1, i % 2, a, $urandom);
      mem_op(0, 0, a, 0);
    end
    done("memory");
    for (i = 0; i < 6; i++) begin
      mem_op(1, 0, 2, ($urandom & 32'hFFFF_8000) | (i == 5 ? 32'h0001_8000 : 0));
      check_cfg();
    end
    done("config");
    for (m = 0; m < 4; m++) begin
      mem_op(1, 0, 2, 32'h2600_0000 | (m << 11));
      check_cfg();
      blocks();
      field_on_i = 1'b1;
      a          = 5 + $urandom % 27;
      mem_op(1, 1, a, $urandom);
      mem_op(0, 1, a, 0);
      field_on_i = 1'b0;
    end
    done("modes");
    // Bit 0 of m enables the interrupt, bit 1 picks level-3 over level-4
    for (m = 0; m < 4; m++) begin
      mem_op(1, 0, 2, 32'h2600_0000 | ((m & 1) << 13) | ((m & 2) << 10));
      @(negedge core_clk_i);
      sak_cl2_sent_i = 1'b1;
      @(negedge core_clk_i);
      sak_cl2_sent_i = 1'b0;
      check(irq_o, 1'b0);
      @(negedge core_clk_i);
      check(irq_o, m[0]);
      check(miso_oe_o, 1'b0);
      ss_n_pin_i = 1'b0;
      repeat (5) @(negedge core_clk_i);
      check(irq_o, 1'b0);
      check(miso_oe_o, 1'b1);
      ss_n_pin_i = 1'b1;
    end
    done("interrupt");
    mem_op(1, 0, 2, 32'h2600_1800);
    frame = 1'b1;
    repeat (4) @(negedge core_clk_i);
    for (i = 0; i < 24; i++) begin
      @(negedge core_clk_i);
      if (i >= 3) check(afe_mod_o, qa[i-3]);
      if (i >= 2) check(miso_o, qb[i-2]);
      if (i >= 2) check(irq_o, qc[i-2]);
      qb.push_back(afe_clk_i);
      qc.push_back(afe_demod_i);
      mosi_pin_i = 1'($urandom % 2);
      qa.push_back(mosi_pin_i);
    end
    check(miso_oe_o, 1'b1);
    frame      = 1'b0;
    ss_n_pin_i = 1'b0;
    mosi_pin_i = 1'b1;
    spi_miso_i = 1'b1;
    spi_irq_i  = 1'b1;
    repeat (5) @(negedge core_clk_i);
    check({afe_mod_o, miso_o, irq_o}, 3'b011);
    spi_irq_i  = 1'b0;
    ss_n_pin_i = 1'b1;
    done("transparent");
    mem_op(1, 0, 2, 32'h2600_0000);
    a = 5 + $urandom % 27;
    b = 5 + (a - 4) % 27;
    mem_op(1, 0, a, $urandom);
    mem_op(1, 1, 3, 1 << a);
    mem_op(1, 0, a, $urandom);
    mem_op(0, 0, a, 0);
    mem_op(1, 0, b, $urandom);
    mem_op(1, 1, 4, 1 << b);
    mem_op(1, 0, 4, 0);
    mem_op(0, 0, 4, 0);
    mem_op(0, 0, b, 0);
    mem_op(0, 1, b, 0);
    done("locks");
    close_out();
  end
endmodule : tb_tmc_core
